/* hdl/pcr_pkg.sv */
// Package of strap codes, ratio encodings and timing counts for the decoder
package pcr_pkg;

   // ************************************************************
   // Strap and ratio widths
   // ************************************************************
   localparam int SYS_STRAP_W  = 4;
   localparam int CORE_STRAP_W = 5;
   localparam int RATIO_W      = 5;  // Ratio in half steps (ratio x 2)

   // ************************************************************
   // System ratio strap codes
   // ************************************************************
   localparam logic [3:0] SYS_CODE_2 = 4'h2;
   localparam logic [3:0] SYS_CODE_3 = 4'h3;
   localparam logic [3:0] SYS_CODE_4 = 4'h4;
   localparam logic [3:0] SYS_CODE_5 = 4'h5;
   localparam logic [3:0] SYS_CODE_6 = 4'h6;
   localparam logic [3:0] SYS_CODE_8 = 4'h8;
   localparam logic [3:0] SYS_CODE_9 = 4'h9;

   // ************************************************************
   // Core ratio strap codes, bit 4 is the first strap bit
   // ************************************************************
   localparam logic [4:0] CORE_CODE_20 = 5'h08;  // 01000
   localparam logic [4:0] CORE_CODE_25 = 5'h0C;  // 01100
   localparam logic [4:0] CORE_CODE_30 = 5'h10;  // 10000
   localparam logic [4:0] CORE_CODE_35 = 5'h1C;  // 11100
   localparam logic [4:0] CORE_CODE_40 = 5'h14;  // 10100
   localparam logic [4:0] CORE_CODE_45 = 5'h0E;  // 01110

   // ************************************************************
   // Ratio values in half steps; zero marks no ratio
   // ************************************************************
   localparam logic [4:0] RATIO_NONE = 5'h00;
   localparam logic [4:0] RATIO_2    = 5'h04;
   localparam logic [4:0] RATIO_2P5  = 5'h05;
   localparam logic [4:0] RATIO_3    = 5'h06;
   localparam logic [4:0] RATIO_3P5  = 5'h07;
   localparam logic [4:0] RATIO_4    = 5'h08;
   localparam logic [4:0] RATIO_4P5  = 5'h09;
   localparam logic [4:0] RATIO_5    = 5'h0A;
   localparam logic [4:0] RATIO_6    = 5'h0C;
   localparam logic [4:0] RATIO_8    = 5'h10;
   localparam logic [4:0] RATIO_9    = 5'h12;

   // ************************************************************
   // Timing: straps settle this long after reset release
   // ************************************************************
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int SETTLE_TIME_NS  = 16;
   localparam int SETTLE_CYCLES   =
      (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);

   // ************************************************************
   // Capture sequencer states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_DONE   = 3'b100
   } pcr_state_e;

endpackage

/* hdl/powerup_clock_ratio_strap_decoder.sv */
// Power-up capture and decode of the clock ratio configuration straps
`timescale 1ns/1ps

module pcr_powerup_clock_ratio_strap_decoder (
   input  wire logic                         clock,         // Reference clock
   input  wire logic                         rst,           // Power-on reset
   input  wire logic [3:0]                   sysRatioStrapPins, // Sys straps
   input  wire logic [3:0]                   busParityStrapPins, // Core [0:3]
   input  wire logic                         coreRatioExtraStrapPin, // Core 4
   output logic      [pcr_pkg::RATIO_W-1:0]  platformRatio, // x2, 0 = none
   output logic      [pcr_pkg::RATIO_W-1:0]  coreRatio,     // x2, 0 = none
   output logic                              sysRatioBad,   // Reserved sys code
   output logic                              coreRatioBad,  // Reserved core code
   output logic                              configDone     // Straps captured
);
   import pcr_pkg::*;

   // ************************************************************
   // Decode functions
   // ************************************************************
   // Reserved codes fall to RATIO_NONE so nothing downstream guesses
   function automatic logic [4:0] sysDecode(input logic [3:0] code);
      logic [4:0] r;
      r = RATIO_NONE;
      unique case (code)
         SYS_CODE_2: r = RATIO_2;
         SYS_CODE_3: r = RATIO_3;
         SYS_CODE_4: r = RATIO_4;
         SYS_CODE_5: r = RATIO_5;
         SYS_CODE_6: r = RATIO_6;
         SYS_CODE_8: r = RATIO_8;
         SYS_CODE_9: r = RATIO_9;
         default:    r = RATIO_NONE;
      endcase
      return r;
   endfunction

   function automatic logic [4:0] coreDecode(input logic [4:0] code);
      logic [4:0] r;
      r = RATIO_NONE;
      unique case (code)
         CORE_CODE_20: r = RATIO_2;
         CORE_CODE_25: r = RATIO_2P5;
         CORE_CODE_30: r = RATIO_3;
         CORE_CODE_35: r = RATIO_3P5;
         CORE_CODE_40: r = RATIO_4;
         CORE_CODE_45: r = RATIO_4P5;
         default:      r = RATIO_NONE;
      endcase
      return r;
   endfunction

   // ************************************************************
   // Capture sequencer
   // ************************************************************
   pcr_state_e state_q;
   pcr_state_e state_d;
   logic [3:0] settle_q;
   logic [3:0] settle_d;
   wire        settleEnd;
   wire        sampleNow;
   wire [4:0]  coreCode;
   wire [4:0]  sysDec;
   wire [4:0]  coreDec;

   // Strap bit 0 is the msb of the code, extra pin is the lsb
   assign coreCode  = {busParityStrapPins, coreRatioExtraStrapPin};
   assign settleEnd = (settle_q == SETTLE_LAST);
   assign sampleNow = (state_q == ST_SAMPLE);
   assign sysDec    = sysDecode(sysRatioStrapPins);
   assign coreDec   = coreDecode(coreCode);

   // Settle first so the pull resistors win over reset-time glitches
   always_comb begin
      state_d  = state_q;
      settle_d = settle_q;
      unique case (state_q)
         ST_SETTLE: begin
            settle_d = settle_q + 4'h1;
            if (settleEnd) begin
               state_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: state_d = ST_DONE;
         ST_DONE:   state_d = ST_DONE;  // Pins now belong to local bus
         default:   state_d = ST_SETTLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q  <= ST_SETTLE;
         settle_q <= 4'h0;
      end else begin
         state_q  <= state_d;
         settle_q <= settle_d;
      end
   end

   // ************************************************************
   // Captured ratios, frozen after the single sample
   // ************************************************************
   // Later pin activity is local bus traffic and must not leak in
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         platformRatio <= RATIO_NONE;
         coreRatio     <= RATIO_NONE;
         sysRatioBad   <= 1'b0;
         coreRatioBad  <= 1'b0;
         configDone    <= 1'b0;
      end else if (sampleNow) begin
         platformRatio <= sysDec;
         coreRatio     <= coreDec;
         sysRatioBad   <= (sysDec == RATIO_NONE);
         coreRatioBad  <= (coreDec == RATIO_NONE);
         configDone    <= 1'b1;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   a_sys_decode: assert property (
      @(posedge clock) disable iff (rst)
      sampleNow && sysRatioStrapPins == SYS_CODE_9
      |=> platformRatio == RATIO_9 && !sysRatioBad)
      else $error("system ratio 9 not decoded");

   a_sys_reserved: assert property (
      @(posedge clock) disable iff (rst)
      sampleNow && (sysRatioStrapPins == 4'h0 || sysRatioStrapPins == 4'h1
                    || sysRatioStrapPins == 4'h7)
      |=> sysRatioBad && platformRatio == RATIO_NONE)
      else $error("reserved system code gave a ratio");

   a_core_decode: assert property (
      @(posedge clock) disable iff (rst)
      sampleNow && coreCode == CORE_CODE_25
      |=> coreRatio == RATIO_2P5 && !coreRatioBad)
      else $error("core ratio 2.5 not decoded");

   a_core_hold: assert property (
      @(posedge clock) disable iff (rst)
      configDone && $past(configDone)
      |-> $stable(coreRatio) && $stable(platformRatio))
      else $error("captured ratio changed after configuration");

   a_done_time: assert property (
      @(posedge clock) disable iff (rst)
      $rose(configDone) |-> $past(state_q, 1) == ST_SAMPLE)
      else $error("configuration done without a sample");

   a_core_reserved: assert property (
      @(posedge clock) disable iff (rst)
      sampleNow && coreCode == 5'h00
      |=> coreRatioBad && coreRatio == RATIO_NONE)
      else $error("reserved core code gave a ratio");

   a_bad_consistent: assert property (
      @(posedge clock) disable iff (rst)
      configDone |-> (coreRatioBad == (coreRatio == RATIO_NONE)))
      else $error("core flag and ratio disagree");

   a_settle_first: assert property (
      @(posedge clock) disable iff (rst)
      $fell(rst) |-> !configDone [*4])
      else $error("straps sampled before settling");

endmodule

/* verification/pcr_strap_board.sv */
// Board strap pull model that also drives bus traffic after capture
`timescale 1ns/1ps

// ************************************************************
// Strap pulls before capture, bus activity afterwards
// ************************************************************
module pcr_strap_board (
   input  wire logic       clock,      // Reference clock
   input  wire logic       configDone, // Capture finished
   input  wire logic [3:0] sysPull,    // Code picked for memory rate
   input  wire logic [4:0] corePull,   // Wanted core code
   output logic      [3:0] sysPins,    // System strap pins
   output logic      [3:0] parityPins, // Core strap pins 0 to 3
   output logic            extraPin    // Core strap pin 4
);
   // Pulls hold until capture; then the shared pins carry bus traffic
   always @(posedge clock) begin
      if (configDone !== 1'b1) begin
         sysPins <= sysPull;
         {parityPins, extraPin} <= corePull;
      end else begin // Toggle so a stale capture cannot pass
         sysPins <= ~sysPins;
         {parityPins, extraPin} <= ~{parityPins, extraPin};
      end
   end
endmodule

/* verification/test_powerup_clock_ratio_strap_decoder.sv */
// Self-checking bench for the clock ratio strap decoder
`timescale 1ns/1ps

module test_powerup_clock_ratio_strap_decoder;
   import pcr_pkg::*;
   localparam logic [4:0] CODES [6] = '{5'h08, 5'h0C, 5'h10, 5'h1C,
                                        5'h14, 5'h0E};
   localparam logic [4:0] RATS  [6] = '{5'h04, 5'h05, 5'h06, 5'h07,
                                        5'h08, 5'h09};
   logic       clock    = 1'b0;
   logic       rst      = 1'b1;
   logic [3:0] sysPull  = 4'h2;
   logic [4:0] corePull = 5'h08;
   logic [3:0] sysPins, parityPins;
   logic       extraPin, sysRatioBad, coreRatioBad, configDone;
   logic [4:0] platformRatio, coreRatio;
   int         badCount = 0;
   int         nChecks  = 0;

   always #2 clock = ~clock;

   pcr_strap_board board (.clock(clock), .configDone(configDone),
      .sysPull(sysPull), .corePull(corePull), .sysPins(sysPins),
      .parityPins(parityPins), .extraPin(extraPin));

   pcr_powerup_clock_ratio_strap_decoder dut (.clock(clock), .rst(rst),
      .sysRatioStrapPins(sysPins), .busParityStrapPins(parityPins),
      .coreRatioExtraStrapPin(extraPin), .platformRatio(platformRatio),
      .coreRatio(coreRatio), .sysRatioBad(sysRatioBad),
      .coreRatioBad(coreRatioBad), .configDone(configDone));

   // ************************************************************
   // Shared helpers
   // ************************************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Reset for 3 cycles, release, count edges until capture ends
   task automatic capture(input logic [3:0] s, input logic [4:0] c);
      int n;
      n = 0;
      @(posedge clock);
      rst      <= 1'b1;
      sysPull  <= s;
      corePull <= c;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      while (n < 20 && configDone !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(5'(n), 5'(SETTLE_CYCLES + 1));
      if (configDone !== 1'b1) end_sim();
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic sys_codes_task();
      logic [3:0] s;
      logic       ok;
      for (int i = 0; i < 16; i++) begin
         s  = 4'(i);
         ok = s inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
         capture(s, 5'h08);
         check(platformRatio, ok ? {s, 1'b0} : 5'h00);
         check({4'h0, sysRatioBad}, {4'h0, ~ok});
      end
   endtask

   task automatic core_codes_task();
      logic [4:0] r;
      for (int i = 0; i < 32; i++) begin
         r = 5'h00;
         for (int k = 0; k < 6; k++) if (CODES[k] == 5'(i)) r = RATS[k];
         capture(4'h3, 5'(i));
         check(coreRatio, r);
         check({4'h0, coreRatioBad}, {4'h0, r == 5'h00});
      end
   endtask

   // Pins toggle as bus lines after capture; results must not move
   task automatic late_change_task();
      capture(4'h9, 5'h0E);
      repeat (9) @(posedge clock);
      #1;
      check(platformRatio, 5'h12);
      check(coreRatio, 5'h09);
      check({4'h0, configDone}, 5'h01);
   endtask

   initial begin
      repeat (3) @(posedge clock);
      sys_codes_task();
      core_codes_task();
      late_change_task();
      end_sim();
   end
endmodule
